// File: sim/program_model.sv
`default_nettype none
`include "run_control_map.svh"
module program_model (
    input  wire logic [`PC_WIDTH-1:0]         pc,
    output run_control_pkg::instr_view_t      instr
);
    timeunit 1ns;
    timeprecision 1ps;
    // word, wait, word, halt; each delay already elapsed so steps are fast
    always_comb begin
        case (pc)
            12'h000: instr = {21'h000015, `OPC_CONTINUE, 1'b1};
            12'h001: instr = {21'h00000a, `OPC_WAIT, 1'b1};
            12'h002: instr = {21'h1f0000, `OPC_CONTINUE, 1'b1};
            default: instr = {21'h1fffff, `OPC_HALT, 1'b1}; // word differs so a halt that loads it shows
        endcase
    end
endmodule
`default_nettype wire

// File: sim/pulse_sequencer_run_control_tb_top.sv
`default_nettype none
module pulse_sequencer_run_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, launch_n = 1'b1, restart_n = 1'b1, run = 1'b0, rewind = 1'b0, halt = 1'b0;
    logic [11:0] pc;
    logic [20:0] chan;
    logic        step, stopped, in_reset, running, waiting;
    run_control_pkg::instr_view_t instr;
    run_control_pkg::run_status_t query;
    int err_count = 0, n_checks = 0;
    pulse_sequencer_run_control pulse_sequencer_run_control_inst (.clk(clk), .resetn(resetn),
        .external_launch_n(launch_n), .external_restart_n(restart_n), .software_run_command(run),
        .software_rewind_command(rewind), .software_halt_command(halt), .instr(instr), .pc(pc), .step(step),
        .channel_out(chan), .software_state_query(query), .stopped(stopped), .in_reset(in_reset),
        .running(running), .waiting(waiting));
    program_model program_model_inst (.pc(pc), .instr(instr));
    // single 100 MHz reference, no second source
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // {launch_n, restart_n, run, rewind, halt} held for n edges, then idle
    task automatic drive(input logic [4:0] v, input int n);
        @(posedge clk);
        {launch_n, restart_n, run, rewind, halt} <= v;
        repeat (n) @(posedge clk);
        {launch_n, restart_n, run, rewind, halt} <= 5'b11000;
    endtask
    // bounded wait for waiting (sel 0) or stopped (sel 1), sampled after the edge
    task automatic settle(input bit sel, input int n);
        for (int i = 0; i < n && (sel ? stopped : waiting) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_run_launch;
        check(in_reset, 1'b1);
        check(running, 1'b0);
        drive(5'b11100, 1);
        #1 check({step, pc}, {1'b1, 12'h000});
        settle(0, 30);
        check({running, waiting}, 2'b11);
        check({step, pc}, {1'b0, 12'h001});
        check(chan, 21'h00000a);
        // two cycles low is above the minimum low time
        drive(5'b01000, 2);
        settle(1, 30);
        check({stopped, running}, 2'b10);
        check(chan, 21'h1f0000);
        check({step, pc}, {1'b0, 12'h003});
        $display("test run_launch done");
    endtask
    task automatic t_refuse_restart;
        drive(5'b01000, 2);
        drive(5'b11100, 1);
        repeat (8) @(posedge clk);
        #1 check(stopped, 1'b1);
        drive(5'b10000, 2);
        repeat (5) @(posedge clk);
        #1 check({in_reset, pc}, {1'b1, 12'h000});
        drive(5'b01000, 2);
        settle(0, 30);
        check(waiting, 1'b1);
        $display("test refuse_restart done");
    endtask
    task automatic t_commands_held;
        drive(5'b11010, 1);
        repeat (2) @(posedge clk);
        #1 check({in_reset, waiting}, 2'b10);
        drive(5'b11100, 1);
        settle(0, 30);
        check(waiting, 1'b1);
        drive(5'b11001, 1);
        repeat (2) @(posedge clk);
        #1 check({in_reset, running}, 2'b10);
        // run held against a held restart: run starts the program, restart wins once through its synchronizer
        drive(5'b10100, 6);
        @(posedge clk);
        #1 check(in_reset, 1'b1);
        repeat (6) @(posedge clk);
        // a held trigger must pass the wait by itself and reach the halt
        drive(5'b01000, 20);
        settle(1, 30);
        check(stopped, 1'b1);
        $display("test commands_held done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1 t_run_launch();
        t_refuse_restart();
        t_commands_held();
        tally_and_finish();
    end
    // watchdog: the tests need well under 500 cycles
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule
bind pulse_sequencer_run_control run_control_chk run_control_chk_inst (.clk(clk), .resetn(resetn),
    .external_launch_n(external_launch_n), .external_restart_n(external_restart_n),
    .software_rewind_command(software_rewind_command), .software_halt_command(software_halt_command),
    .instr(instr), .channel_out(channel_out), .software_state_query(software_state_query),
    .stopped(stopped), .in_reset(in_reset), .running(running), .waiting(waiting));
`default_nettype wire

// File: sim/run_control_chk.sv
`default_nettype none
`include "run_control_map.svh"
module run_control_chk (
    input wire logic                         clk,
    input wire logic                         resetn,
    input wire logic                         external_launch_n,
    input wire logic                         external_restart_n,
    input wire logic                         software_rewind_command,
    input wire logic                         software_halt_command,
    input wire run_control_pkg::instr_view_t instr,
    input wire logic [`CHANNEL_COUNT-1:0]    channel_out,
    input wire run_control_pkg::run_status_t software_state_query,
    input wire logic                         stopped,
    input wire logic                         in_reset,
    input wire logic                         running,
    input wire logic                         waiting
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // restart quiet long enough that nothing is still in the synchronizer
    sequence restart_quiet;
        external_restart_n [*4];
    endsequence
    sequence halt_seen;
        running && !waiting && instr.done && instr.opcode == `OPC_HALT && external_restart_n;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property (in_reset |-> !running && !stopped && !waiting)
        else $error("status flag up in reset state");
    chk_wait_running: assert property (waiting |-> running)
        else $error("waiting without running");
    chk_query_mirror: assert property (software_state_query == {stopped, in_reset, running, waiting})
        else $error("state query differs from pins");
    chk_halt_stops: assert property (restart_quiet ##0 halt_seen ##0 (!software_rewind_command
        && !software_halt_command) |=> stopped && !running)
        else $error("halt opcode did not stop");
    chk_halt_keeps: assert property ($rose(stopped) |-> $stable(channel_out))
        else $error("outputs changed on halt");
    chk_stop_deaf: assert property (restart_quiet ##0 stopped && !software_rewind_command && !software_halt_command |=> stopped)
        else $error("stopped state left without rearm");
    chk_cmd_rearm: assert property (software_rewind_command || software_halt_command |=> in_reset && !running)
        else $error("command did not return to reset");
    chk_launch_resume: assert property (waiting && $fell(external_launch_n) |-> ##[1:5] !waiting)
        else $error("trigger did not resume wait");
    chk_restart_rewind: assert property ($fell(external_restart_n) |-> ##[1:5] in_reset)
        else $error("restart did not reach reset state");
endmodule
`default_nettype wire

// File: src/pulse_sequencer_run_control.sv
`default_nettype none
`include "run_control_map.svh"
module pulse_sequencer_run_control #(
    parameter int CHANNELS = `CHANNEL_COUNT,
    parameter int PC_W     = `PC_WIDTH
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        external_launch_n,
    input  wire logic                        external_restart_n,
    input  wire logic                        software_run_command,
    input  wire logic                        software_rewind_command,
    input  wire logic                        software_halt_command,
    input  wire run_control_pkg::instr_view_t instr,
    output logic [PC_W-1:0]                  pc,
    output logic                             step,
    output logic [CHANNELS-1:0]              channel_out,
    output run_control_pkg::run_status_t     software_state_query,
    output logic                             stopped,
    output logic                             in_reset,
    output logic                             running,
    output logic                             waiting
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic launch_meta;
    logic launch_sync;
    logic launch_prev;
    logic restart_meta;
    logic restart_sync;

    // reset to the pulled-up idle level so no false edge follows reset
    // two-stage trigger synchronizer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            launch_meta <= 1'b1;
            launch_sync <= 1'b1;
            launch_prev <= 1'b1;
        end else begin
            launch_meta <= external_launch_n;
            launch_sync <= launch_meta;
            launch_prev <= launch_sync;
        end
    end

    // only the second stage is ever read; the first may still be settling
    // two-stage restart synchronizer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            restart_meta <= 1'b1;
            restart_sync <= 1'b1;
        end else begin
            restart_meta <= external_restart_n;
            restart_sync <= restart_meta;
        end
    end

    // a held-low trigger re-fires every cycle, so the edge and the level both count;
    // the pin path costs three cycles, and a pulse shorter than one clock may be missed
    // falling edge detect
    wire launch_edge  = launch_prev & ~launch_sync;
    wire launch_event = launch_edge | ~launch_sync;
    wire restart_req  = ~restart_sync;

    ////////////////////////////////////////////////////////////////////////
    // state machine
    run_control_pkg::run_state_t state;
    run_control_pkg::run_state_t next_state;
    logic [PC_W-1:0]             next_pc;
    logic                        armed;      // low after a stop until rewound
    logic                        next_armed;

    // opcode decode, only meaningful once the current word's delay has run out
    wire is_halt = instr.done && (instr.opcode == `OPC_HALT);
    wire is_wait = instr.done && (instr.opcode == `OPC_WAIT);
    // first program address, sized once so every rewind path loads the same value
    wire [PC_W-1:0] pc_first = PC_W'(`PC_FIRST);
    wire [PC_W-1:0] pc_plus  = pc + PC_W'(1);  // wraps at the top of program memory
    // run command or trigger both count as a start request while idle
    wire start_req = software_run_command | launch_event;

    // next-state logic; restart and rewind outrank everything so a stuck program can
    // always be pulled back, and the halt command is treated the same way
    always_comb begin
        next_state = state;
        next_pc    = pc;
        next_armed = armed;
        step       = 1'b0;
        if (restart_req || software_rewind_command) begin
            next_state = run_control_pkg::ST_RESET;
            next_pc    = pc_first;
            next_armed = 1'b1;
        end else if (software_halt_command) begin
            next_state = run_control_pkg::ST_RESET;
            next_pc    = pc_first;
            next_armed = 1'b1;
        end else begin
            case (state)
                run_control_pkg::ST_RESET: begin
                    // run or trigger starts at first
                    if (start_req) begin
                        next_state = run_control_pkg::ST_RUNNING;
                        next_pc    = pc_first;
                    end
                end
                run_control_pkg::ST_RUNNING: begin
                    // a trigger here is ignored: the sequencer is not idle
                    if (is_halt) begin
                        next_state = run_control_pkg::ST_STOPPED;
                        next_armed = 1'b0;
                    end else if (is_wait) begin
                        // park on the wait, pc stays on it
                        next_state = run_control_pkg::ST_WAITING;
                    end else if (instr.done) begin
                        step    = 1'b1;
                        next_pc = pc_plus;
                    end
                end
                run_control_pkg::ST_WAITING: begin
                    if (start_req) begin
                        next_state = run_control_pkg::ST_RUNNING;
                        next_pc    = pc_plus;
                        step       = 1'b1;
                    end
                end
                run_control_pkg::ST_STOPPED: begin
                    // every rearm also moves the state to reset, so the armed test is
                    // a second guard that keeps a stopped program deaf to triggers
                    // triggers ignored until rearmed
                    if (armed && start_req) begin
                        next_state = run_control_pkg::ST_RUNNING;
                        next_pc    = pc_first;
                    end
                end
                default: begin
                    next_state = run_control_pkg::ST_RESET;
                    next_pc    = pc_first;
                end
            endcase
        end
    end

    // state, program counter and arming
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= run_control_pkg::ST_RESET;
            pc    <= PC_W'(`PC_FIRST);
            armed <= 1'b1;
        end else begin
            state <= next_state;
            pc    <= next_pc;
            armed <= next_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel outputs: load while running, hold otherwise so a stop freezes them;
    // the word under a halt is loaded only while its delay runs, not once done is set, so the pins keep the last loaded value
    wire load_word = (state == run_control_pkg::ST_RUNNING) && !is_halt;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_out <= CHANNELS'(`WORD_RESET);
        end else if (load_word) begin
            channel_out <= instr.outputs[CHANNELS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status pins, registered from the next state so they track the state register
    // without an extra cycle of lag
    // status decode
    wire next_stopped  = next_state == run_control_pkg::ST_STOPPED;
    wire next_in_reset = next_state == run_control_pkg::ST_RESET;
    wire next_waiting  = next_state == run_control_pkg::ST_WAITING;
    // a paused program still counts as executing, so running covers waiting too
    wire next_running  = next_state == run_control_pkg::ST_RUNNING || next_waiting;

    // status registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stopped  <= 1'b0;
            in_reset <= 1'b1;
            running  <= 1'b0;
            waiting  <= 1'b0;
        end else begin
            stopped  <= next_stopped;
            in_reset <= next_in_reset;
            running  <= next_running;
            waiting  <= next_waiting;
        end
    end

    // software query mirrors the pins so both views always agree
    assign software_state_query = '{stopped: stopped, reset: in_reset, running: running, waiting: waiting};

endmodule
`default_nettype wire

// File: src/run_control_map.svh
`ifndef RUN_CONTROL_MAP_SVH
`define RUN_CONTROL_MAP_SVH
// opcode values seen by the run controller
`define OPC_WIDTH      4
`define OPC_CONTINUE   4'h0
`define OPC_HALT       4'h1
`define OPC_WAIT       4'h8
// output channel count and program address width
`define CHANNEL_COUNT  21
`define PC_WIDTH       12
`define PC_FIRST       12'h000
`define WORD_RESET     21'h000000
`endif

// File: src/run_control_pkg.sv
`default_nettype none
`include "run_control_map.svh"
package run_control_pkg;
    // run states of the sequencer
    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_RUNNING = 2'b01,
        ST_WAITING = 2'b10,
        ST_STOPPED = 2'b11
    } run_state_t;

    // status outputs grouped for software query and pins
    typedef struct packed {
        logic stopped;
        logic reset;
        logic running;
        logic waiting;
    } run_status_t;

    // current instruction as presented by the program memory
    typedef struct packed {
        logic [`CHANNEL_COUNT-1:0] outputs;
        logic [`OPC_WIDTH-1:0]     opcode;
        logic                      done;
    } instr_view_t;
endpackage
`default_nettype wire
